// ==== logic/imsc_irq_status.sv ====
// Masked interrupt status and write-one-to-clear logic on AXI4-Lite.
`timescale 1ns/1ps

module imsc_irq_status #(
    parameter int NEV = imsc_pkg::NUM_EVENTS
) (
    input  wire logic            CLOCK,
    input  wire logic            RST_N,
    input  wire logic [NEV-1:0]  EVENT_SET,
    input  wire logic            S_AXI_AWVALID,
    output logic                 S_AXI_AWREADY,
    input  wire logic [7:0]      S_AXI_AWADDR,
    input  wire logic            S_AXI_WVALID,
    output logic                 S_AXI_WREADY,
    input  wire logic [31:0]     S_AXI_WDATA,
    input  wire logic [3:0]      S_AXI_WSTRB,
    output logic                 S_AXI_BVALID,
    input  wire logic            S_AXI_BREADY,
    output logic [1:0]           S_AXI_BRESP,
    input  wire logic            S_AXI_ARVALID,
    output logic                 S_AXI_ARREADY,
    input  wire logic [7:0]      S_AXI_ARADDR,
    output logic                 S_AXI_RVALID,
    input  wire logic            S_AXI_RREADY,
    output logic [31:0]          S_AXI_RDATA,
    output logic [1:0]           S_AXI_RRESP,
    output logic [NEV-1:0]       RAW_STATUS,
    output logic [NEV-1:0]       MASKED_STATUS
);

    // ************************************************************
    // Write channel capture
    // ************************************************************
    logic            aw_have_ff;
    logic [7:0]      aw_addr_ff;
    logic            w_have_ff;
    logic [31:0]     w_data_ff;
    logic [3:0]      w_strb_ff;
    logic            bvalid_ff;
    logic [1:0]      bresp_ff;
    logic            arvalid_seen;
    logic            rvalid_ff;
    logic [31:0]     rdata_ff;
    logic [1:0]      rresp_ff;
    logic [NEV-1:0]  raw_ff;
    logic [NEV-1:0]  mask_ff;
    logic [NEV-1:0]  masked_ff;
    logic            awready_ff;
    logic            wready_ff;
    logic            arready_ff;

    wire             aw_take    = S_AXI_AWVALID && !aw_have_ff && !bvalid_ff;
    wire             w_take     = S_AXI_WVALID && !w_have_ff && !bvalid_ff;
    wire             wr_fire    = aw_have_ff && w_have_ff && !bvalid_ff;
    wire             wr_clear   = wr_fire &&
                                  aw_addr_ff == imsc_pkg::OFS_IRQ_CLEAR;
    wire             wr_mask    = wr_fire &&
                                  aw_addr_ff == imsc_pkg::OFS_IRQ_MASK;
    wire             wr_known   = wr_clear || wr_mask ||
                                  aw_addr_ff == imsc_pkg::OFS_RAW_STATUS ||
                                  aw_addr_ff == imsc_pkg::OFS_MASKED_STATUS;

    // Only the low byte lanes that carry the twelve bits are honoured.
    wire [15:0]      lane_mask  = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wire [15:0]      wdata_lo   = w_data_ff[15:0] & lane_mask;
    // Ones clear, zeros leave the flag alone.
    wire [NEV-1:0]   clear_word = wr_clear ? wdata_lo[NEV-1:0] : '0;
    wire [NEV-1:0]   clear_bits;

    // An event arriving together with its clear wins, so none is lost.
    wire [NEV-1:0]   nxt_raw    = (raw_ff & ~clear_bits) | EVENT_SET;
    wire [NEV-1:0]   nxt_mask   = wr_mask ? wdata_lo[NEV-1:0] : mask_ff;
    // Masked status is raw AND mask, so a clear drops both together.
    wire [NEV-1:0]   nxt_masked = nxt_raw & nxt_mask;

    // ************************************************************
    // Read decode
    // ************************************************************
    wire             ar_take    = S_AXI_ARVALID && !rvalid_ff;
    wire [31:0]      raw_word;
    wire [31:0]      mask_word  = {{(32-NEV){1'b0}}, mask_ff};
    wire [31:0]      mis_word;
    wire             rd_mis     = S_AXI_ARADDR ==
                                  imsc_pkg::OFS_MASKED_STATUS;
    wire             rd_raw     = S_AXI_ARADDR == imsc_pkg::OFS_RAW_STATUS;
    wire             rd_mask    = S_AXI_ARADDR == imsc_pkg::OFS_IRQ_MASK;
    wire             rd_clear   = S_AXI_ARADDR == imsc_pkg::OFS_IRQ_CLEAR;
    wire             rd_known   = rd_mis || rd_raw || rd_mask || rd_clear;
    // The clear register holds no state; a read gives a fixed word.
    wire [31:0]      nxt_rdata  = rd_mis   ? mis_word  :
                                  rd_raw   ? raw_word  :
                                  rd_mask  ? mask_word :
                                  imsc_pkg::CLEAR_READ_VALUE;
    wire [1:0]       nxt_rresp  = rd_known ? imsc_pkg::RESP_OKAY :
                                             imsc_pkg::RESP_SLVERR;

    assign arvalid_seen = ar_take;

    // ************************************************************
    // Ready flags
    // ************************************************************
    // Each ready is the registered copy of what the holding flags will be
    // after this edge, so no bus output is reached through logic.
    wire             nxt_aw_have = aw_take || (aw_have_ff && !wr_fire);
    wire             nxt_w_have  = w_take || (w_have_ff && !wr_fire);
    wire             nxt_bvalid  = wr_fire || (bvalid_ff && !S_AXI_BREADY);
    wire             nxt_rvalid  = ar_take || (rvalid_ff && !S_AXI_RREADY);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            arready_ff <= 1'b1;
        end else begin
            awready_ff <= !nxt_aw_have && !nxt_bvalid;
            wready_ff  <= !nxt_w_have && !nxt_bvalid;
            arready_ff <= !nxt_rvalid;
        end
    end

    // ************************************************************
    // Per-event fields
    // ************************************************************
    // Naming each field pins the bit layout to the twelve events of the
    // map; a different NEV needs this section rewritten as well.
    wire             rx_full_clear;
    wire             tx_empty_clear;
    wire             rx_request_clear;
    wire             tx_request_clear;
    wire             arbitration_loss_clear;
    wire             stop_seen_clear;
    wire             start_seen_clear;
    wire             no_ack_clear;
    wire             dma_send_done_clear;
    wire             dma_receive_done_clear;
    wire             clock_timeout_clear;
    wire             master_event_clear;
    wire             rx_full_raw;
    wire             tx_empty_raw;
    wire             rx_request_raw;
    wire             tx_request_raw;
    wire             arbitration_loss_raw;
    wire             stop_seen_raw;
    wire             start_seen_raw;
    wire             no_ack_raw;
    wire             dma_send_done_raw;
    wire             dma_receive_done_raw;
    wire             clock_timeout_raw;
    wire             master_event_raw;
    wire             rx_full_masked;
    wire             tx_empty_masked;
    wire             rx_request_masked;
    wire             tx_request_masked;
    wire             arbitration_loss_masked;
    wire             stop_seen_masked;
    wire             start_seen_masked;
    wire             no_ack_masked;
    wire             dma_send_done_masked;
    wire             dma_receive_done_masked;
    wire             clock_timeout_masked;
    wire             master_event_masked;

    assign rx_full_clear           = clear_word[imsc_pkg::BIT_RX_FULL];
    assign tx_empty_clear          = clear_word[imsc_pkg::BIT_TX_EMPTY];
    assign rx_request_clear        = clear_word[imsc_pkg::BIT_RX_REQUEST];
    assign tx_request_clear        = clear_word[imsc_pkg::BIT_TX_REQUEST];
    assign arbitration_loss_clear  = clear_word[imsc_pkg::BIT_ARB_LOSS];
    assign stop_seen_clear         = clear_word[imsc_pkg::BIT_STOP_SEEN];
    assign start_seen_clear        = clear_word[imsc_pkg::BIT_START_SEEN];
    assign no_ack_clear            = clear_word[imsc_pkg::BIT_NO_ACK];
    assign dma_send_done_clear     = clear_word[imsc_pkg::BIT_DMA_SEND];
    assign dma_receive_done_clear  = clear_word[imsc_pkg::BIT_DMA_RECV];
    assign clock_timeout_clear     = clear_word[imsc_pkg::BIT_CLK_TIMEOUT];
    assign master_event_clear      = clear_word[imsc_pkg::BIT_MASTER_EVENT];
    assign rx_full_raw             = raw_ff[imsc_pkg::BIT_RX_FULL];
    assign tx_empty_raw            = raw_ff[imsc_pkg::BIT_TX_EMPTY];
    assign rx_request_raw          = raw_ff[imsc_pkg::BIT_RX_REQUEST];
    assign tx_request_raw          = raw_ff[imsc_pkg::BIT_TX_REQUEST];
    assign arbitration_loss_raw    = raw_ff[imsc_pkg::BIT_ARB_LOSS];
    assign stop_seen_raw           = raw_ff[imsc_pkg::BIT_STOP_SEEN];
    assign start_seen_raw          = raw_ff[imsc_pkg::BIT_START_SEEN];
    assign no_ack_raw              = raw_ff[imsc_pkg::BIT_NO_ACK];
    assign dma_send_done_raw       = raw_ff[imsc_pkg::BIT_DMA_SEND];
    assign dma_receive_done_raw    = raw_ff[imsc_pkg::BIT_DMA_RECV];
    assign clock_timeout_raw       = raw_ff[imsc_pkg::BIT_CLK_TIMEOUT];
    assign master_event_raw        = raw_ff[imsc_pkg::BIT_MASTER_EVENT];
    assign rx_full_masked          = masked_ff[imsc_pkg::BIT_RX_FULL];
    assign tx_empty_masked         = masked_ff[imsc_pkg::BIT_TX_EMPTY];
    assign rx_request_masked       = masked_ff[imsc_pkg::BIT_RX_REQUEST];
    assign tx_request_masked       = masked_ff[imsc_pkg::BIT_TX_REQUEST];
    assign arbitration_loss_masked = masked_ff[imsc_pkg::BIT_ARB_LOSS];
    assign stop_seen_masked        = masked_ff[imsc_pkg::BIT_STOP_SEEN];
    assign start_seen_masked       = masked_ff[imsc_pkg::BIT_START_SEEN];
    assign no_ack_masked           = masked_ff[imsc_pkg::BIT_NO_ACK];
    assign dma_send_done_masked    = masked_ff[imsc_pkg::BIT_DMA_SEND];
    assign dma_receive_done_masked = masked_ff[imsc_pkg::BIT_DMA_RECV];
    assign clock_timeout_masked    = masked_ff[imsc_pkg::BIT_CLK_TIMEOUT];
    assign master_event_masked     = masked_ff[imsc_pkg::BIT_MASTER_EVENT];

    assign clear_bits = {rx_full_clear,
                         tx_empty_clear,
                         rx_request_clear,
                         tx_request_clear,
                         arbitration_loss_clear,
                         stop_seen_clear,
                         start_seen_clear,
                         no_ack_clear,
                         dma_send_done_clear,
                         dma_receive_done_clear,
                         clock_timeout_clear,
                         master_event_clear};

    // Reserved bits above the events read as zero.
    assign raw_word = {{(32-NEV){1'b0}},
                       rx_full_raw,          tx_empty_raw,
                       rx_request_raw,       tx_request_raw,
                       arbitration_loss_raw, stop_seen_raw,
                       start_seen_raw,       no_ack_raw,
                       dma_send_done_raw,    dma_receive_done_raw,
                       clock_timeout_raw,    master_event_raw};
    assign mis_word = {{(32-NEV){1'b0}},
                       rx_full_masked,          tx_empty_masked,
                       rx_request_masked,       tx_request_masked,
                       arbitration_loss_masked, stop_seen_masked,
                       start_seen_masked,       no_ack_masked,
                       dma_send_done_masked,    dma_receive_done_masked,
                       clock_timeout_masked,    master_event_masked};

    // ************************************************************
    // Write path registers
    // ************************************************************
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            aw_have_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
        end else if (aw_take) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_have_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            w_have_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else if (w_take) begin
            w_have_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA;
            w_strb_ff <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_have_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= imsc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            // Writes to the read-only status words are accepted and ignored.
            bresp_ff  <= wr_known ? imsc_pkg::RESP_OKAY :
                                    imsc_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Read path registers
    // ************************************************************
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= imsc_pkg::RESP_OKAY;
        end else if (arvalid_seen) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end else if (S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Flag registers
    // ************************************************************
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            raw_ff    <= imsc_pkg::RST_RAW;
            mask_ff   <= imsc_pkg::RST_MASK;
            masked_ff <= imsc_pkg::RST_RAW;
        end else begin
            raw_ff    <= nxt_raw;
            mask_ff   <= nxt_mask;
            masked_ff <= nxt_masked;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Every output is a flip-flop, so no bus signal depends on a valid
    // input within the same cycle.
    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY  = wready_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RDATA   = rdata_ff;
    assign S_AXI_RRESP   = rresp_ff;
    assign RAW_STATUS    = raw_ff;
    assign MASKED_STATUS = masked_ff;

endmodule : imsc_irq_status

// ==== logic/imsc_pkg.sv ====
// Package with register map, field layout and reset values of the block.
package imsc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  OFS_RAW_STATUS    = 8'h14;
    localparam logic [7:0]  OFS_MASKED_STATUS = 8'h18;
    localparam logic [7:0]  OFS_IRQ_CLEAR     = 8'h1c;
    localparam logic [7:0]  OFS_IRQ_MASK      = 8'h10;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int          NUM_EVENTS        = 12;
    localparam int          BIT_RX_FULL       = 11;
    localparam int          BIT_TX_EMPTY      = 10;
    localparam int          BIT_RX_REQUEST    = 9;
    localparam int          BIT_TX_REQUEST    = 8;
    localparam int          BIT_ARB_LOSS      = 7;
    localparam int          BIT_STOP_SEEN     = 6;
    localparam int          BIT_START_SEEN    = 5;
    localparam int          BIT_NO_ACK        = 4;
    localparam int          BIT_DMA_SEND      = 3;
    localparam int          BIT_DMA_RECV      = 2;
    localparam int          BIT_CLK_TIMEOUT   = 1;
    localparam int          BIT_MASTER_EVENT  = 0;
    localparam logic [11:0] RST_RAW           = 12'h000;
    localparam logic [11:0] RST_MASK          = 12'h000;
    localparam logic [31:0] CLEAR_READ_VALUE  = 32'h00000000;

    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;

endpackage : imsc_pkg

// ==== verif/imsc_irq_checker.sv ====
// Checker of bus answers and interrupt flags at the block's ports.
`timescale 1ns/1ps
module imsc_irq_checker #(
    parameter int NEV = 12
) (
    input wire logic           CLOCK,
    input wire logic           RST_N,
    input wire logic           S_AXI_AWVALID,
    input wire logic           S_AXI_AWREADY,
    input wire logic           S_AXI_WVALID,
    input wire logic           S_AXI_WREADY,
    input wire logic           S_AXI_BVALID,
    input wire logic           S_AXI_BREADY,
    input wire logic           S_AXI_ARVALID,
    input wire logic           S_AXI_ARREADY,
    input wire logic           S_AXI_RVALID,
    input wire logic           S_AXI_RREADY,
    input wire logic [7:0]     S_AXI_AWADDR,
    input wire logic [7:0]     S_AXI_ARADDR,
    input wire logic [31:0]    S_AXI_WDATA,
    input wire logic [31:0]    S_AXI_RDATA,
    input wire logic [1:0]     S_AXI_BRESP,
    input wire logic [1:0]     S_AXI_RRESP,
    input wire logic [NEV-1:0] EVENT_SET,
    input wire logic [NEV-1:0] RAW_STATUS,
    input wire logic [NEV-1:0] MASKED_STATUS
);
    logic [7:0]     wa_ff, ra_ff;
    logic [NEV-1:0] wd_ff, clr_bits;
    logic           bv_ff;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    // A clear lands on the edge that raises the write answer, so the
    // address and data of that write are kept until then.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wa_ff <= 8'h00;
            ra_ff <= 8'h00;
            wd_ff <= '0;
            bv_ff <= 1'b0;
        end else begin
            bv_ff <= S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) wa_ff <= S_AXI_AWADDR;
            if (S_AXI_WVALID && S_AXI_WREADY) wd_ff <= S_AXI_WDATA[NEV-1:0];
            if (S_AXI_ARVALID && S_AXI_ARREADY) ra_ff <= S_AXI_ARADDR;
        end
    end
    assign clr_bits = (S_AXI_BVALID && !bv_ff && wa_ff == 8'h1c) ? wd_ff : '0;

    // ************************************************************
    // Assertions
    // ************************************************************
    raw_clear_a:
    assert property (((RAW_STATUS | MASKED_STATUS) & clr_bits
        & ~$past(EVENT_SET)) == '0) else $error("cleared flag still set");
    raw_keep_a:
    assert property ((RAW_STATUS & ~clr_bits) == (($past(RAW_STATUS)
        | $past(EVENT_SET)) & ~clr_bits)) else $error("raw flag changed");
    mask_subset_a:
    assert property ((MASKED_STATUS & ~RAW_STATUS) == '0)
        else $error("masked flag without raw flag");
    masked_read_a:
    assert property ($rose(S_AXI_RVALID) && ra_ff == 8'h18 |->
        S_AXI_RDATA == 32'($past(MASKED_STATUS))) else $error("bad status");
    clear_read_a:
    assert property ($rose(S_AXI_RVALID) && ra_ff == 8'h1c |->
        S_AXI_RDATA == 32'h0 && S_AXI_RRESP == 2'h0) else $error("bad read");
    clear_okay_a:
    assert property ($rose(S_AXI_BVALID) && wa_ff == 8'h1c |->
        S_AXI_BRESP == 2'h0) else $error("clear write refused");
    bresp_hold_a:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
        && $stable(S_AXI_BRESP)) else $error("write answer dropped");
    rdata_hold_a:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA)) else $error("read answer dropped");
    write_answer_a:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID) else $error("no answer");

    cover property (clr_bits != '0);
    cover property ($rose(S_AXI_RVALID) && ra_ff == 8'h18 && S_AXI_RDATA != 0);
    cover property ($rose(S_AXI_RVALID) && S_AXI_RRESP == 2'h2);
endmodule : imsc_irq_checker

bind imsc_irq_status imsc_irq_checker #(.NEV(NEV)) u_checker (.*);

// ==== verif/imsc_irq_status_tb.sv ====
// Self-checking bench for the interrupt status and clear block.
`timescale 1ns/1ps
module imsc_irq_status_tb;
    logic        clock = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, seen;
    logic [1:0]  bresp, rresp;
    logic [11:0] ev = 12'h000, raw, masked;
    int          fail_count = 0, checks = 0, i;

    always #25 clock = ~clock;

    imsc_irq_status dut (.CLOCK(clock), .RST_N(rst_n), .EVENT_SET(ev),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .RAW_STATUS(raw), .MASKED_STATUS(masked));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, want %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // The answer ready is raised only after both offers are taken, on the edge
    // that raises the answer, so the design never has to hold its answer.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock);
            if (bvalid && bready) break;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bready <= !awvalid && !wvalid;
        end
        bready <= 1'b0;
        if (n == 40) fail_count++;
        if (n == 40) report_and_stop();
        check(32'(bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      output logic [31:0] d);
        int n;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock);
            if (rvalid && rready) break;
            if (arready) arvalid <= 1'b0;
            rready <= !arvalid;
        end
        d = rdata;
        rready <= 1'b0;
        if (n == 40) fail_count++;
        if (n == 40) report_and_stop();
        check(32'(rresp), 32'(er));
    endtask : rd

    task automatic pulse(input logic [11:0] v);
        @(posedge clock);
        ev <= v;
        @(posedge clock);
        ev <= 12'h000;
        @(posedge clock);
    endtask : pulse

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        check(32'(raw | masked), 32'h0);
        rd(8'h18, 2'h0, seen);
        check(seen, 32'h0);
        wr(8'h10, 32'h0aa, 2'h0);
        pulse(12'hfff);
        check(32'(raw), 32'hfff);
        check(32'(masked), 32'h0aa);
        rd(8'h10, 2'h0, seen);
        check(seen, 32'h0aa);
        rd(8'h14, 2'h0, seen);
        check(seen, 32'hfff);
        wr(8'h18, 32'hffffffff, 2'h0);
        rd(8'h18, 2'h0, seen);
        check(seen, 32'h0aa);
        wr(8'h10, 32'hfff, 2'h0);
        wr(8'h1c, 32'h0, 2'h0);
        check(32'(masked), 32'hfff);
        for (i = 11; i >= 0; i--) begin
            wr(8'h1c, 32'h1 << i, 2'h0);
            check(32'(raw), (32'h1 << i) - 32'h1);
            check(32'(masked), (32'h1 << i) - 32'h1);
        end
        rd(8'h1c, 2'h0, seen);
        check(seen, 32'h0);
        rd(8'h40, 2'h2, seen);
        wr(8'h40, 32'h1, 2'h2);
        pulse(12'hfff);
        rst_n <= 1'b0;
        @(posedge clock);
        check(32'(raw | masked), 32'h0);
        rst_n <= 1'b1;
        rd(8'h10, 2'h0, seen);
        check(seen, 32'h0);
        pulse(12'h001);
        check(32'(raw), 32'h1);
        check(32'(masked), 32'h0);
        rd(8'h18, 2'h0, seen);
        check(seen, 32'h0);
        report_and_stop();
    end
endmodule : imsc_irq_status_tb
